// ### design/fpss_feedback_divider.sv
`timescale 1ns/100ps
module fpss_feedback_divider (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    vco_tick,
  input  wire fpss_pkg::fpss_div_cfg_t cfg,
  output fpss_pkg::fpss_div_out_t      div_out
);

  fpss_pkg::fpss_div_state_t state;
  fpss_pkg::fpss_div_state_t next_state;

  logic        dual;
  logic [5:0]  ratio;
  logic [12:0] main_load;

  // ==========================================================
  // Divider step
  always_comb begin
    dual = fpss_pkg::fpss_is_dual(cfg.mode);
    // Bypass only counts in fixed modes; dual modes ignore it
    if (cfg.bypass && !dual) begin
      main_load = 13'h0001;
    end else if (cfg.main_count == 13'h0000) begin
      main_load = 13'h0001;
    end else begin
      main_load = cfg.main_count;
    end
    ratio = fpss_pkg::fpss_low_ratio(cfg.mode);
    if (dual && state.swallow_left != 6'h00) begin
      ratio = ratio + 6'h01;
    end
    next_state = state;
    next_state.out = '0;
    if (cfg.counter_reset) begin
      next_state.pre_cnt      = '0;
      next_state.swallow_left = dual ? cfg.swallow : fpss_pkg::FPSS_SWALLOW_RESET;
      next_state.main_left    = main_load;
    end else if (vco_tick) begin
      if (state.pre_cnt >= ratio - 6'h01) begin
        next_state.pre_cnt = '0;
        next_state.out.prescale_out = 1'b1;
        if (state.swallow_left != 6'h00) begin
          next_state.swallow_left = state.swallow_left - 6'h01;
          next_state.out.swallow_out = (state.swallow_left == 6'h01);
        end
        if (state.main_left <= 13'h0001) begin
          // Cycle of low*B + A ticks ends; reload both counters
          next_state.out.feedback_out = 1'b1;
          next_state.main_left = main_load;
          next_state.swallow_left = dual ? cfg.swallow : fpss_pkg::FPSS_SWALLOW_RESET;
        end else begin
          next_state.main_left = state.main_left - 13'h0001;
        end
      end else begin
        next_state.pre_cnt = state.pre_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state.pre_cnt      <= '0;
      state.swallow_left <= fpss_pkg::FPSS_SWALLOW_RESET;
      state.main_left    <= 13'h0001;
      state.out          <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign div_out = state.out;

endmodule : fpss_feedback_divider

// ### design/fpss_pkg.sv
package fpss_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] FPSS_ADDR_FB_CTRL    = 8'h16;
  localparam logic [7:0] FPSS_ADDR_STATUS_SEL = 8'h17;

  // ==========================================================
  // Field positions
  localparam int FPSS_BYPASS_BIT = 3;
  localparam int FPSS_MODE_LSB   = 0;
  localparam int FPSS_MODE_W     = 3;
  localparam int FPSS_SEL_LSB    = 2;
  localparam int FPSS_SEL_W      = 6;

  // ==========================================================
  // Reset values
  localparam logic [2:0] FPSS_MODE_RESET   = 3'h6;
  localparam logic       FPSS_BYPASS_RESET = 1'b0;
  localparam logic [5:0] FPSS_SEL_RESET    = 6'h00;
  localparam logic [5:0] FPSS_SWALLOW_RESET = 6'h00;

  // ==========================================================
  // Status selections, top bit clear
  localparam logic [5:0] FPSS_SEL_FB_DLY   = 6'h01;
  localparam logic [5:0] FPSS_SEL_REF_DLY  = 6'h02;
  localparam logic [5:0] FPSS_SEL_SWALLOW  = 6'h03;
  localparam logic [5:0] FPSS_SEL_PRESCALE = 6'h04;
  localparam logic [5:0] FPSS_SEL_PFD_UP   = 6'h05;
  localparam logic [5:0] FPSS_SEL_PFD_DN   = 6'h06;
  localparam int         FPSS_SEL_TOP      = 5;

  // ==========================================================
  // Prescaler table: low ratio and dual-modulus flag per code
  function automatic logic [5:0] fpss_low_ratio(input logic [2:0] code);
    unique case (code)
      3'h0:    return 6'h01;
      3'h1:    return 6'h02;
      3'h2:    return 6'h02;
      3'h3:    return 6'h04;
      3'h4:    return 6'h08;
      3'h5:    return 6'h10;
      3'h6:    return 6'h20;
      default: return 6'h03;
    endcase
  endfunction : fpss_low_ratio

  function automatic logic fpss_is_dual(input logic [2:0] code);
    return (code >= 3'h2) && (code <= 3'h6);
  endfunction : fpss_is_dual

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [2:0]  mode;
    logic        bypass;
    logic [5:0]  swallow;
    logic [12:0] main_count;
    logic        counter_reset;
  } fpss_div_cfg_t;

  typedef struct packed {
    logic prescale_out;
    logic swallow_out;
    logic feedback_out;
  } fpss_div_out_t;

  typedef struct packed {
    logic [5:0]    pre_cnt;
    logic [5:0]    swallow_left;
    logic [12:0]   main_left;
    fpss_div_out_t out;
  } fpss_div_state_t;

  typedef struct packed {
    logic [2:0] mode;
    logic       bypass;
    logic [5:0] sel;
    logic [7:0] rdata;
    logic       fb_dly;
    logic       status;
  } fpss_regs_t;

endpackage : fpss_pkg

// ### design/fpss_top.sv
`timescale 1ns/100ps
// What this block does
// - Bypass of main counter only matters in fixed-divide prescaler modes.
// - Bypass set makes main counter divide by one; cleared means normal.
// - Three-bit prescaler code picks fixed or dual-modulus division.
// - Code 010 divides by three with swallow nonzero, else two.
// - Codes 011, 100, 101 divide 5/4, 9/8, 17/16.
// - Code 110 is reset default, dividing 33 or 32.
// - Six-bit select drives status pin; writes only while override clear.
// - Unlisted low selections and zero hold the status pin at ground.
// - Selections one to six route divider and detector signals.
// - Top-bit selections follow reference monitor encoding; zero is ground.
// - Six-bit swallow counter belongs to feedback divider, resets zero.
module fpss_top #(
  parameter int MAIN_W = 13
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  output logic      [7:0]  reg_rdata,
  input  wire logic        status_override,
  input  wire logic        vco_tick,
  input  wire logic [5:0]  swallow_value,
  input  wire logic [12:0] main_value,
  input  wire logic        counter_reset,
  input  wire logic        ref_div_delayed,
  input  wire logic        pfd_up,
  input  wire logic        pfd_down,
  input  wire logic [31:0] reference_monitor_pin_sources,
  output logic             prescale_out,
  output logic             feedback_out,
  output logic             status_pin
);

  // ==========================================================
  // Elaboration check
  if (MAIN_W != 13) begin : g_bad_width
    $error("fpss_top: main counter width must be 13");
  end

  fpss_pkg::fpss_regs_t    regs;
  fpss_pkg::fpss_regs_t    next_regs;
  fpss_pkg::fpss_div_cfg_t div_cfg;
  fpss_pkg::fpss_div_out_t div_out;

  logic fb_sel;
  logic ref_sel;

  // ==========================================================
  // Feedback divider
  always_comb begin
    div_cfg.mode          = regs.mode;
    div_cfg.bypass        = regs.bypass;
    div_cfg.swallow       = swallow_value;
    div_cfg.main_count    = main_value;
    div_cfg.counter_reset = counter_reset;
  end

  fpss_feedback_divider u_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .vco_tick(vco_tick),
    .cfg     (div_cfg),
    .div_out (div_out)
  );

  // ==========================================================
  // Registers and status selection
  always_comb begin
    fb_sel  = (reg_addr == fpss_pkg::FPSS_ADDR_FB_CTRL);
    ref_sel = (reg_addr == fpss_pkg::FPSS_ADDR_STATUS_SEL);
    next_regs = regs;
    if (reg_write && fb_sel) begin
      next_regs.mode   = reg_wdata[fpss_pkg::FPSS_MODE_LSB +: fpss_pkg::FPSS_MODE_W];
      next_regs.bypass = reg_wdata[fpss_pkg::FPSS_BYPASS_BIT];
    end
    // Locked selection: write is dropped, not queued
    if (reg_write && ref_sel && !status_override) begin
      next_regs.sel = reg_wdata[fpss_pkg::FPSS_SEL_LSB +: fpss_pkg::FPSS_SEL_W];
    end
    next_regs.rdata = 8'h00;
    if (fb_sel) begin
      next_regs.rdata[fpss_pkg::FPSS_MODE_LSB +: fpss_pkg::FPSS_MODE_W] = regs.mode;
      next_regs.rdata[fpss_pkg::FPSS_BYPASS_BIT] = regs.bypass;
    end else if (ref_sel) begin
      next_regs.rdata[fpss_pkg::FPSS_SEL_LSB +: fpss_pkg::FPSS_SEL_W] = regs.sel;
    end
    // One-cycle delay stands in for the feedback output delay
    next_regs.fb_dly = div_out.feedback_out;
    if (regs.sel[fpss_pkg::FPSS_SEL_TOP]) begin
      if (regs.sel[4:0] == 5'h00) begin
        next_regs.status = 1'b0;
      end else begin
        next_regs.status = reference_monitor_pin_sources[regs.sel[4:0]];
      end
    end else begin
      unique case (regs.sel)
        fpss_pkg::FPSS_SEL_FB_DLY:   next_regs.status = regs.fb_dly;
        fpss_pkg::FPSS_SEL_REF_DLY:  next_regs.status = ref_div_delayed;
        fpss_pkg::FPSS_SEL_SWALLOW:  next_regs.status = div_out.swallow_out;
        fpss_pkg::FPSS_SEL_PRESCALE: next_regs.status = div_out.prescale_out;
        fpss_pkg::FPSS_SEL_PFD_UP:   next_regs.status = pfd_up;
        fpss_pkg::FPSS_SEL_PFD_DN:   next_regs.status = pfd_down;
        default:                     next_regs.status = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regs.mode   <= fpss_pkg::FPSS_MODE_RESET;
      regs.bypass <= fpss_pkg::FPSS_BYPASS_RESET;
      regs.sel    <= fpss_pkg::FPSS_SEL_RESET;
      regs.rdata  <= 8'h00;
      regs.fb_dly <= 1'b0;
      regs.status <= 1'b0;
    end else begin
      regs <= next_regs;
    end
  end

  assign reg_rdata    = regs.rdata;
  assign status_pin   = regs.status;
  assign prescale_out = div_out.prescale_out;
  assign feedback_out = div_out.feedback_out;

endmodule : fpss_top

// ### sim/fpss_host.sv
`timescale 1ns/100ps
module fpss_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  input  wire logic [7:0] reg_rdata
);
  // ==========================================================
  // Host side of the serial control port
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    // Stale data must not look like a held value
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : fpss_host

// ### sim/fpss_top_sva.sv
`timescale 1ns/100ps
module fpss_top_sva #(
  parameter int MAIN_W = 13
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic [7:0]  reg_rdata,
  input wire logic        status_override,
  input wire logic        counter_reset,
  input wire logic        pfd_up,
  input wire logic [31:0] reference_monitor_pin_sources,
  input wire logic        prescale_out,
  input wire logic        feedback_out,
  input wire logic        status_pin
);
  // ==========================================================
  // Shadow of the two registers, as a host would expect them
  logic [2:0] mode;
  logic       byp;
  logic [5:0] sel;
  wire        gnd  = (sel[4:0] == 5'h00) || (!sel[5] && sel > 6'h06);
  wire        rbit = reference_monitor_pin_sources[sel[4:0]];
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode <= 3'h6;
      byp  <= 1'b0;
      sel  <= 6'h00;
    end else if (reg_write && reg_addr == 8'h16) begin
      mode <= reg_wdata[2:0];
      byp  <= reg_wdata[3];
    end else if (reg_write && reg_addr == 8'h17 && !status_override) begin
      sel <= reg_wdata[7:2];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_fb_readback: assert property (
    reg_addr == 8'h16 |=> reg_rdata == {4'h0, $past(byp), $past(mode)})
    else $error("feedback control readback wrong");
  a_sel_readback: assert property (
    reg_addr == 8'h17 |=> reg_rdata == {$past(sel), 2'b00})
    else $error("status select readback wrong");
  a_unmapped_zero: assert property (
    reg_addr != 8'h16 && reg_addr != 8'h17 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ground_level: assert property (
    gnd |=> !status_pin)
    else $error("status pin not grounded");
  a_prescale_route: assert property (
    sel == 6'h04 |=> status_pin == $past(prescale_out))
    else $error("prescaler not on status pin");
  a_pfd_route: assert property (
    sel == 6'h05 |=> status_pin == $past(pfd_up))
    else $error("detector up not on status pin");
  a_fb_route: assert property (
    sel == 6'h01 ##1 sel == 6'h01 |=> status_pin == $past(feedback_out, 2))
    else $error("delayed feedback not on status pin");
  a_reference_monitor_pin_route: assert property (
    sel[5] && sel[4:0] != 5'h00 |=> status_pin == $past(rbit))
    else $error("monitor source not on status pin");
  a_hold_quiet: assert property (
    counter_reset |=> !prescale_out && !feedback_out)
    else $error("divider pulsed while held");
endmodule : fpss_top_sva

// ### sim/fpss_top_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module fpss_top_tb_top;
  // ==========================================================
  // Stimulus and checking
  logic        clk   = 1'b0;
  logic        rst_b = 1'b0;
  logic        ovr   = 1'b0;
  logic        tick  = 1'b0;
  logic        crst  = 1'b0;
  logic [5:0]  a_val = 6'h01;
  logic [12:0] b_val = 13'h0002;
  logic [15:0] cyc   = 16'h0000;
  logic [7:0]  addr, wdata, rdata, d;
  logic        wr_en, pre, fb, stat;
  int          err_count = 0;
  int          checked = 0;
  int          lows[8] = '{1, 2, 2, 4, 8, 16, 32, 3};
  logic [5:0]  codes[11] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
                             6'h20, 6'h21, 6'h3F};
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 16'h0001;
  fpss_host host_u (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_en),
    .reg_rdata(rdata));
  fpss_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata),
    .reg_write(wr_en), .reg_rdata(rdata), .status_override(ovr), .vco_tick(tick),
    .swallow_value(a_val), .main_value(b_val), .counter_reset(crst),
    .ref_div_delayed(cyc[1]), .pfd_up(cyc[0]), .pfd_down(cyc[2]),
    .reference_monitor_pin_sources({2{cyc}}), .prescale_out(pre), .feedback_out(fb),
    .status_pin(stat));
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // Ticks every cycle, so the feedback period shows in clock cycles
  task automatic period(input logic [2:0] m, input logic byp, input int exp);
    int n;
    int np;
    host_u.wr(8'h16, {4'h0, byp, m});
    crst <= 1'b1;
    @(posedge clk);
    crst <= 1'b0;
    tick <= 1'b1;
    for (n = 0; n < 200 && fb !== 1'b1; n++) @(posedge clk);
    n = 0;
    np = 0;
    // One prescaler pulse per main count step within a feedback period
    do begin
      @(posedge clk);
      n++;
      if (pre === 1'b1) np++;
    end while (fb !== 1'b1 && n < 200);
    `CHK(n, exp)
    `CHK(np, (byp && !(m inside {[3'h2:3'h6]})) ? 1 : int'(b_val))
    tick <= 1'b0;
  endtask : period
  task automatic t_ratios();
    for (int m = 0; m < 8; m++) period(m[2:0], 1'b0, lows[m] * 2 + ((m inside {[2:6]}) ? 1 : 0));
    foreach (codes[i]) if (i < 2 || i == 7) period(i[2:0], 1'b1, lows[i]);
    a_val <= 6'h00;
    period(3'h2, 1'b0, 4);
    a_val <= 6'h01;
    // Bypass must be ignored in a dual-modulus code
    b_val <= 13'h0003;
    period(3'h3, 1'b1, 13);
    b_val <= 13'h0002;
  endtask : t_ratios
  task automatic t_regs();
    host_u.rd(8'h16, d); `CHK(d, 8'h06)
    host_u.rd(8'h17, d); `CHK(d, 8'h00)
    host_u.rd(8'h40, d); `CHK(d, 8'h00)
    host_u.wr(8'h16, 8'hF9);
    host_u.rd(8'h16, d); `CHK(d, 8'h09)
  endtask : t_regs
  task automatic t_status();
    ovr <= 1'b1;
    host_u.wr(8'h17, 8'h10);
    host_u.rd(8'h17, d); `CHK(d, 8'h00)
    ovr <= 1'b0;
    tick <= 1'b1;
    foreach (codes[i]) begin
      host_u.wr(8'h17, {codes[i], 2'b00});
      host_u.rd(8'h17, d); `CHK(d, {codes[i], 2'b00})
      if (i == 0 || i == 7 || i == 8) `CHK(stat, 1'b0)
    end
    tick <= 1'b0;
  endtask : t_status
  always @(posedge clk) if (cyc == 16'h4E20) begin
    err_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_ratios();
    t_status();
    conclude();
  end
endmodule : fpss_top_tb_top
bind fpss_top fpss_top_sva #(.MAIN_W(MAIN_W)) chk_u (
  .clk                          (clk),
  .rst_b                        (rst_b),
  .reg_addr                     (reg_addr),
  .reg_wdata                    (reg_wdata),
  .reg_write                    (reg_write),
  .reg_rdata                    (reg_rdata),
  .status_override              (status_override),
  .counter_reset                (counter_reset),
  .pfd_up                       (pfd_up),
  .reference_monitor_pin_sources(reference_monitor_pin_sources),
  .prescale_out                 (prescale_out),
  .feedback_out                 (feedback_out),
  .status_pin                   (status_pin)
);
